// file: include/ppm_cfg.svh
// Register offsets, field positions, reset values and widths of the port pin mux block.
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
`define PPM_ADDR_W 4
`define PPM_OFF_C_PINS 4'h0
`define PPM_OFF_C_LAT 4'h1
`define PPM_OFF_C_DIR 4'h2
`define PPM_OFF_D_PINS 4'h3
`define PPM_OFF_D_LAT 4'h4
`define PPM_OFF_D_DIR 4'h5
`define PPM_OFF_G_PINS 4'h6
`define PPM_OFF_MEMCTL 4'h7
`define PPM_OFF_CONFIG 4'h8
`define PPM_OFF_STATUS 4'h9
`define PPM_PULLUP_BIT 7
`define PPM_EBUS_DIS_BIT 7
`define PPM_CFG_CMP2_BIT 0
`define PPM_CFG_PMP_BIT 1
`define PPM_DIR_RESET 8'hff
`define PPM_LAT_RESET 8'h00
`define PPM_G_RESET 8'h80
`define PPM_MEM_RESET 8'h80
`define PPM_CFG_RESET 8'h03
`define PPM_PIN_CMP2 1
`define PPM_PIN_SDI 4
`define PPM_PIN_SDO 5
`define PPM_PIN_TX 6
`define PPM_PIN_RX 7
`endif

// file: include/ppm_pkg.sv
// Types shared by the port pin mux block.
package ppm_pkg;
  typedef logic [7:0] ppm_byte_t;
  // Who owns the second port, highest priority first.
  typedef enum logic [1:0] {
    PPM_OWN_EBUS = 2'b00,
    PPM_OWN_PMP = 2'b01,
    PPM_OWN_PORT = 2'b10
  } ppm_owner_t;
endpackage

// file: core/ppm_port_mux.sv
// Pin control and peripheral override mux for two 8-bit bidirectional ports.
//
// Behaviour
// - Each second-port pin has own direction bit.
// - Serial data out overrides latch on pin 5.
// - Pin 4 feeds serial data input.
// - Two-wire data overrides pin 4; buffer selectable.
// - Usart sync data out overrides pins 6/7.
// - Pin 7 feeds usart receive input.
// - Pin 6 feeds usart sync clock input.
// - Overriding functions ignore the direction bit; here only two-wire data does, the others gate on it.
// - Compare channel two on pin 1 when routed.
// - Second port becomes input on every reset.
// - Second port usable only with memory bus disabled.
// - Memory bus drives second port, overrides direction.
// - Parallel port outranks all except memory bus.
// - Parallel port routed only when routing bit one.
// - Parallel port active selects TTL input buffers.
// - Clear pull-up bit enables second-port pull-ups.
// - Pull-up off while pin is output.
// - Reset disables all second-port pull-ups.
// - Normal second port uses Schmitt buffers.
// - Direction reads return stored contents.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ppm_cfg.svh"

module ppm_port_mux
  import ppm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter bit HAS_EBUS = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`PPM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [WIDTH-1:0] c_pin_in,
  output logic [WIDTH-1:0] c_pin_out,
  output logic [WIDTH-1:0] c_pin_oe,
  input wire logic [WIDTH-1:0] d_pin_in,
  output logic [WIDTH-1:0] d_pin_out,
  output logic [WIDTH-1:0] d_pin_oe,
  output logic [WIDTH-1:0] d_pullup_en,
  output logic d_ttl_select,
  output logic c4_ttl_select,
  input wire logic serial1_data_out_en,
  input wire logic serial1_data_out,
  output logic serial1_data_in,
  input wire logic two_wire1_data_en,
  input wire logic two_wire1_data_drive,
  input wire logic two_wire1_data_ttl,
  input wire logic usart1_sync_data_en,
  input wire logic usart1_transmit,
  input wire logic usart1_sync_data,
  output logic usart1_receive,
  output logic usart1_sync_clock,
  input wire logic compare2_pwm_en,
  input wire logic compare2_pwm_out_a,
  output logic compare2_capture_in,
  input wire logic ebus_active,
  input wire logic [WIDTH-1:0] mux_addr_data_low_byte_out,
  input wire logic mux_addr_data_low_byte_oe,
  output logic [WIDTH-1:0] ebus_data_in,
  input wire logic pmp_active,
  input wire logic [WIDTH-1:0] pmp_data_out,
  input wire logic pmp_data_oe,
  output logic [WIDTH-1:0] pmp_data_in
);

  // The pin numbering of the overrides fixes the port width at eight.
  if (WIDTH != 8) begin : g_width_check
    $error("ppm_port_mux serves 8-bit ports only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic rst_meta_q;
  logic rst_n_q;

  // Release is synchronised so all registers leave reset on the same edge.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [WIDTH-1:0] c_s1_q, c_s2_q, c_s3_q, c_lvl_q;
  logic [WIDTH-1:0] d_s1_q, d_s2_q, d_s3_q, d_lvl_q;

  // Pins are asynchronous; a level counts only once two stages agree.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      c_s1_q <= `PPM_LAT_RESET;
      c_s2_q <= `PPM_LAT_RESET;
      c_s3_q <= `PPM_LAT_RESET;
      c_lvl_q <= `PPM_LAT_RESET;
      d_s1_q <= `PPM_LAT_RESET;
      d_s2_q <= `PPM_LAT_RESET;
      d_s3_q <= `PPM_LAT_RESET;
      d_lvl_q <= `PPM_LAT_RESET;
    end else begin
      c_s1_q <= c_pin_in;
      c_s2_q <= c_s1_q;
      c_s3_q <= c_s2_q;
      c_lvl_q <= (c_s2_q & c_s3_q) | (c_lvl_q & (c_s2_q | c_s3_q));
      d_s1_q <= d_pin_in;
      d_s2_q <= d_s1_q;
      d_s3_q <= d_s2_q;
      d_lvl_q <= (d_s2_q & d_s3_q) | (d_lvl_q & (d_s2_q | d_s3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  ppm_byte_t c_lat_q, c_dir_q, d_lat_q, d_dir_q, g_q, mem_q, cfg_q;

  function automatic logic hit(input logic [`PPM_ADDR_W-1:0] a,
                               input logic [`PPM_ADDR_W-1:0] off);
    hit = reg_write && (a == off);
  endfunction

  // Latch writes through either the pin or latch address land in the latch.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      c_lat_q <= `PPM_LAT_RESET;
      d_lat_q <= `PPM_LAT_RESET;
    end else begin
      if (hit(reg_addr, `PPM_OFF_C_PINS) || hit(reg_addr, `PPM_OFF_C_LAT)) begin
        c_lat_q <= reg_wdata;
      end
      if (hit(reg_addr, `PPM_OFF_D_PINS) || hit(reg_addr, `PPM_OFF_D_LAT)) begin
        d_lat_q <= reg_wdata;
      end
    end
  end

  // Every reset makes all pins inputs and turns the pull-ups off.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      c_dir_q <= `PPM_DIR_RESET;
      d_dir_q <= `PPM_DIR_RESET;
      g_q <= `PPM_G_RESET;
      mem_q <= `PPM_MEM_RESET;
      cfg_q <= `PPM_CFG_RESET;
    end else begin
      if (hit(reg_addr, `PPM_OFF_C_DIR)) begin
        c_dir_q <= reg_wdata;
      end
      if (hit(reg_addr, `PPM_OFF_D_DIR)) begin
        d_dir_q <= reg_wdata;
      end
      if (hit(reg_addr, `PPM_OFF_G_PINS)) begin
        g_q <= reg_wdata;
      end
      if (hit(reg_addr, `PPM_OFF_MEMCTL)) begin
        mem_q <= reg_wdata;
      end
      if (hit(reg_addr, `PPM_OFF_CONFIG)) begin
        cfg_q <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second-port ownership.

  ppm_owner_t d_owner;
  logic pmp_routed;

  // Memory bus outranks the parallel port, which outranks port logic.
  assign pmp_routed = pmp_active && cfg_q[`PPM_CFG_PMP_BIT];
  always_comb begin
    if (HAS_EBUS && ebus_active && !mem_q[`PPM_EBUS_DIS_BIT]) begin
      d_owner = PPM_OWN_EBUS;
    end else if (pmp_routed) begin
      d_owner = PPM_OWN_PMP;
    end else begin
      d_owner = PPM_OWN_PORT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive decisions (combinational), registered below.

  logic [WIDTH-1:0] c_out_d, c_oe_d, d_out_d, d_oe_d, pu_d;

  // Two-wire and usart overrides set direction themselves (usart drives pins 6/7 while direction bit 6 is set); compare and serial follow the direction bits.
  always_comb begin
    c_out_d = c_lat_q;
    c_oe_d = ~c_dir_q;
    if (compare2_pwm_en && cfg_q[`PPM_CFG_CMP2_BIT]) begin
      c_out_d[`PPM_PIN_CMP2] = compare2_pwm_out_a;
      c_oe_d[`PPM_PIN_CMP2] = ~c_dir_q[`PPM_PIN_CMP2];
    end
    if (two_wire1_data_en) begin
      c_out_d[`PPM_PIN_SDI] = 1'b0;
      c_oe_d[`PPM_PIN_SDI] = two_wire1_data_drive;
    end
    if (serial1_data_out_en && !c_dir_q[`PPM_PIN_SDO]) begin
      c_out_d[`PPM_PIN_SDO] = serial1_data_out;
      c_oe_d[`PPM_PIN_SDO] = 1'b1;
    end
    if (usart1_sync_data_en && c_dir_q[`PPM_PIN_TX]) begin
      c_out_d[`PPM_PIN_TX] = usart1_transmit;
      c_oe_d[`PPM_PIN_TX] = 1'b1;
      c_out_d[`PPM_PIN_RX] = usart1_sync_data;
      c_oe_d[`PPM_PIN_RX] = 1'b1;
    end
    unique case (d_owner)
      PPM_OWN_EBUS: begin
        d_out_d = mux_addr_data_low_byte_out;
        d_oe_d = {WIDTH{mux_addr_data_low_byte_oe}};
      end
      PPM_OWN_PMP: begin
        d_out_d = pmp_data_out;
        d_oe_d = {WIDTH{pmp_data_oe}};
      end
      PPM_OWN_PORT: begin
        d_out_d = d_lat_q;
        d_oe_d = ~d_dir_q;
      end
    endcase
    // Pull-ups only on input pins, and only while the control bit is clear.
    pu_d = {WIDTH{~g_q[`PPM_PULLUP_BIT]}} & ~d_oe_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; the pin path carries one cycle of latency.

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      c_pin_out <= `PPM_LAT_RESET;
      c_pin_oe <= `PPM_LAT_RESET;
      d_pin_out <= `PPM_LAT_RESET;
      d_pin_oe <= `PPM_LAT_RESET;
      d_pullup_en <= `PPM_LAT_RESET;
      d_ttl_select <= 1'b0;
      c4_ttl_select <= 1'b0;
    end else begin
      c_pin_out <= c_out_d;
      c_pin_oe <= c_oe_d;
      d_pin_out <= d_out_d;
      d_pin_oe <= d_oe_d;
      d_pullup_en <= pu_d;
      // TTL while the memory bus or parallel port owns the pins, else Schmitt.
      d_ttl_select <= (d_owner != PPM_OWN_PORT);
      c4_ttl_select <= two_wire1_data_en && two_wire1_data_ttl;
    end
  end

  // Peripheral inputs come from synchronised pin levels.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      serial1_data_in <= 1'b0;
      usart1_receive <= 1'b1;
      usart1_sync_clock <= 1'b0;
      compare2_capture_in <= 1'b0;
      ebus_data_in <= `PPM_LAT_RESET;
      pmp_data_in <= `PPM_LAT_RESET;
    end else begin
      serial1_data_in <= c_dir_q[`PPM_PIN_SDI] & c_lvl_q[`PPM_PIN_SDI];
      usart1_receive <= ~c_dir_q[`PPM_PIN_RX] | c_lvl_q[`PPM_PIN_RX];
      usart1_sync_clock <= c_dir_q[`PPM_PIN_TX] & c_lvl_q[`PPM_PIN_TX];
      compare2_capture_in <= c_lvl_q[`PPM_PIN_CMP2];
      ebus_data_in <= d_lvl_q;
      pmp_data_in <= d_lvl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the read strobe.

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= `PPM_LAT_RESET;
    end else if (reg_read) begin
      unique case (reg_addr)
        `PPM_OFF_C_PINS: reg_rdata <= c_lvl_q;
        `PPM_OFF_C_LAT: reg_rdata <= c_lat_q;
        `PPM_OFF_C_DIR: reg_rdata <= c_dir_q;
        `PPM_OFF_D_PINS: reg_rdata <= d_lvl_q;
        `PPM_OFF_D_LAT: reg_rdata <= d_lat_q;
        `PPM_OFF_D_DIR: reg_rdata <= d_dir_q;
        `PPM_OFF_G_PINS: reg_rdata <= g_q;
        `PPM_OFF_MEMCTL: reg_rdata <= mem_q;
        `PPM_OFF_CONFIG: reg_rdata <= cfg_q;
        `PPM_OFF_STATUS: reg_rdata <= {6'h00, d_owner};
        default: reg_rdata <= `PPM_LAT_RESET;
      endcase
    end else begin
      reg_rdata <= `PPM_LAT_RESET;
    end
  end

endmodule

// file: verif/ppm_chk_sva.sv
// Concurrent checks on the ports of the port pin mux block.
`timescale 1ns/1ps
module ppm_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] c_pin_out,
  input wire logic [7:0] c_pin_oe,
  input wire logic [7:0] d_pin_oe,
  input wire logic [7:0] d_pullup_en,
  input wire logic d_ttl_select,
  input wire logic two_wire1_data_en,
  input wire logic two_wire1_data_drive,
  input wire logic ebus_active,
  input wire logic pmp_active
);
  logic own;
  // The port owns the second port only while neither bus claims it.
  assign own = !ebus_active && !pmp_active;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Read data, direction, pull-up, buffer and override relations.
  rd_idle_a: assert property (!reg_read || reg_addr > 4'h9 |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  dir_read_a: assert property (reg_write && reg_addr == 4'h5 ##2 reg_read &&
    reg_addr == 4'h5 |=> reg_rdata == $past(reg_wdata, 3)) else $error("direction readback");
  // The direction register takes one edge and the registered pin enable one more.
  dir_oe_a: assert property (own[*2] ##0 reg_write && reg_addr == 4'h5 ##1 own[*2]
    |-> d_pin_oe == ~$past(reg_wdata, 2)) else $error("direction not applied");
  oe_hold_a: assert property ((own && !reg_write)[*2] |=> $stable(d_pin_oe))
    else $error("direction changed unprompted");
  pull_out_a: assert property (own[*2] |-> (d_pullup_en & d_pin_oe) == 8'h00)
    else $error("pull-up on an output");
  reset_a: assert property ($rose(resetn) |-> d_pin_oe == 8'h00 && d_pullup_en == 8'h00)
    else $error("second port not input after reset");
  ttl_a: assert property ($rose(d_ttl_select) |-> $past(pmp_active))
    else $error("buffer switched without parallel port");
  od_a: assert property ((two_wire1_data_en && two_wire1_data_drive)[*2]
    |-> c_pin_oe[4] && !c_pin_out[4]) else $error("two-wire pin not pulled low");
  dir_cov: cover property (reg_write && reg_addr == 4'h5);
  pmp_cov: cover property (pmp_active && d_ttl_select);
  od_cov: cover property (two_wire1_data_en && two_wire1_data_drive);
endmodule
bind ppm_port_mux ppm_chk chk (.*);

// file: verif/ppm_board.sv
// Board model: pin levels made from device drive, board drive and pull-ups.
`timescale 1ns/1ps
module ppm_board (
  input wire logic clock,
  input wire logic [7:0] p_out,
  input wire logic [7:0] p_oe,
  input wire logic [7:0] p_pu,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] lvl
);
  logic [7:0] tgl_q = 8'h55;
  // A floating pin flips every cycle, so a stale value never passes for a match.
  always @(posedge clock) tgl_q <= ~tgl_q;
  // Device drive wins over the board, the board over a pull-up.
  assign lvl = (p_oe & p_out) | (~p_oe & ext_drv & ext_val)
    | (~p_oe & ~ext_drv & (p_pu | tgl_q));
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the port pin mux block.
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic reg_write, reg_read, ebus_active, pmp_active, pmp_data_oe, compare2_pwm_en;
  logic serial1_data_out_en, serial1_data_out, two_wire1_data_en, two_wire1_data_drive;
  logic two_wire1_data_ttl, usart1_sync_data_en, usart1_transmit, usart1_sync_data;
  logic compare2_pwm_out_a, mux_addr_data_low_byte_oe, d_ttl_select, c4_ttl_select;
  logic serial1_data_in, usart1_receive, usart1_sync_clock, compare2_capture_in;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, c_pin_in, c_pin_out, c_pin_oe, d_pin_in, d_pin_out;
  logic [7:0] d_pin_oe, d_pullup_en, mux_addr_data_low_byte_out, pmp_data_out;
  logic [7:0] ebus_data_in, pmp_data_in, c_ext, c_drv, d_ext, d_drv, lat_m, dir_m, ev;
  logic [11:0] rt [8] = '{12'h100, 12'h2ff, 12'h400, 12'h5ff, 12'h780, 12'h803, 12'h902, 12'hf00};
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 7095;
  ppm_port_mux uut (.*);
  ppm_board cb (.clock(clock), .p_out(c_pin_out), .p_oe(c_pin_oe), .p_pu(8'h00),
    .ext_val(c_ext), .ext_drv(c_drv), .lvl(c_pin_in));
  ppm_board db (.clock(clock), .p_out(d_pin_out), .p_oe(d_pin_oe), .p_pu(d_pullup_en),
    .ext_val(d_ext), .ext_drv(d_drv), .lvl(d_pin_in));
  // Clock, and a cycle ceiling well above the 155 or so cycles the run needs.
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset, register defaults, random port traffic, then each override in turn.
  initial begin
    {reg_write, reg_read, ebus_active, pmp_active, pmp_data_oe, compare2_pwm_en,
      serial1_data_out_en, serial1_data_out, two_wire1_data_en, two_wire1_data_drive,
      two_wire1_data_ttl, usart1_sync_data_en, usart1_transmit, usart1_sync_data,
      compare2_pwm_out_a, mux_addr_data_low_byte_oe, reg_addr, reg_wdata, c_ext, c_drv,
      d_ext, d_drv, mux_addr_data_low_byte_out, pmp_data_out} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    settle(3);
    chk(d_pin_oe | d_pullup_en, 8'h00);
    for (int i = 0; i < 8; i++) rd(rt[i][11:8], rt[i][7:0]);
    wr(4'h6, 8'h00);
    repeat (6) begin
      lat_m = 8'($random(seed));
      dir_m = 8'($random(seed));
      ev = 8'($random(seed));
      d_drv <= dir_m;
      d_ext <= ev;
      wr(4'h4, lat_m);
      wr(4'h5, dir_m);
      rd(4'h5, dir_m);
      rd(4'h4, lat_m);
      settle(5);
      chk(d_pin_oe, ~dir_m);
      chk(d_pin_out & ~dir_m, lat_m & ~dir_m);
      chk(d_pullup_en, dir_m);
      chk({7'h00, d_ttl_select}, 8'h00);
      rd(4'h3, (lat_m & ~dir_m) | (ev & dir_m));
      chk(ebus_data_in, (lat_m & ~dir_m) | (ev & dir_m));
      chk(pmp_data_in, (lat_m & ~dir_m) | (ev & dir_m));
    end
    pmp_data_out <= ev;
    pmp_data_oe <= 1'b1;
    pmp_active <= 1'b1;
    settle(3);
    chk(d_pin_out, ev);
    chk(d_pin_oe, 8'hff);
    chk({7'h00, d_ttl_select}, 8'h01);
    wr(4'h8, 8'h01);
    settle(2);
    chk(d_pin_oe, ~dir_m);
    wr(4'h8, 8'h03);
    wr(4'h7, 8'h00);
    ebus_active <= 1'b1;
    mux_addr_data_low_byte_oe <= 1'b1;
    mux_addr_data_low_byte_out <= ~ev;
    settle(3);
    chk(d_pin_out, ~ev);
    chk(d_pin_oe, 8'hff);
    rd(4'h9, 8'h00);
    wr(4'h7, 8'h80);
    settle(2);
    chk(d_pin_out, ev);
    c_drv <= 8'hd0;
    c_ext <= 8'h90;
    {serial1_data_out_en, serial1_data_out, compare2_pwm_en, compare2_pwm_out_a} <= 4'hf;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'hdd);
    settle(5);
    chk(c_pin_out & 8'h22, 8'h22);
    chk({4'h0, compare2_capture_in, serial1_data_in, usart1_receive, usart1_sync_clock},
      8'h0e);
    c_drv <= 8'h10;
    {usart1_sync_data_en, usart1_transmit, usart1_sync_data} <= 3'h6;
    {two_wire1_data_en, two_wire1_data_drive, two_wire1_data_ttl} <= 3'h7;
    settle(3);
    chk(c_pin_oe & 8'hd0, 8'hd0);
    chk(c_pin_out & 8'hd0, 8'h40);
    chk({7'h00, c4_ttl_select}, 8'h01);
    complete_run();
  end
endmodule
